// file: hw/dli_params.svh
// Constants of the display-list interpreter: field positions, codes, counts
`ifndef DLI_PARAMS_SVH
`define DLI_PARAMS_SVH

// ****************************************
// Header field positions
// ****************************************
`define DLI_TYPE_HI 31
`define DLI_TYPE_LO 24
`define DLI_CMD_HI 23
`define DLI_CMD_LO 16
`define DLI_CNT_HI 23
`define DLI_CNT_LO 16
`define DLI_ADDR_HI 15
`define DLI_ADDR_LO 0
`define DLI_FLAG_VBL 0
`define DLI_VTX_HI 1
`define DLI_VTX_LO 0

// ****************************************
// Type codes
// ****************************************
`define DLI_T_PIXEL 8'h00
`define DLI_T_POINT_PLOT_DEPTH 8'h01
`define DLI_T_LINE 8'h02
`define DLI_T_LINE2I 8'h03
`define DLI_T_LINE2IP 8'h04
`define DLI_T_TRAP 8'h05
`define DLI_T_VTX2I 8'h06
`define DLI_T_VTX2IP 8'h07
`define DLI_T_RECTP 8'h09
`define DLI_T_BMPP 8'h0b
`define DLI_T_COPYP 8'h0d
`define DLI_T_COPYALTP 8'h0f
`define DLI_T_TEXP 8'h11
`define DLI_T_BLTTEXP 8'h13
`define DLI_T_VSET 8'h70
`define DLI_T_VSETP 8'h71
`define DLI_T_DRAW 8'hf0
`define DLI_T_REGSET 8'hf1
`define DLI_T_WAIT 8'hfc
`define DLI_T_IRQ 8'hfd
`define DLI_T_NOP 8'hff

// ****************************************
// Draw sub-codes
// ****************************************
`define DLI_C_PIXEL 8'h00
`define DLI_C_POINT_PLOT_DEPTH 8'h01
`define DLI_G_LINE 3'h1
`define DLI_G_BLT 3'h2
`define DLI_G_TRI 3'h3
`define DLI_G_FLUSH 3'h6
`define DLI_G_SHAPE 3'h7
`define DLI_C_FILL 8'h41
`define DLI_C_PATDRAW 8'h42
`define DLI_C_BITMAP 8'h43
`define DLI_C_COPY_UL 8'h44
`define DLI_C_COPY_LR 8'h47
`define DLI_C_TEXLOAD 8'h48
`define DLI_C_TILELOAD 8'h49
`define DLI_C_RTRI 8'h60
`define DLI_C_FLAGFAN 8'h63
`define DLI_C_PIX_DRAIN 8'hc1
`define DLI_C_Z_DRAIN 8'hc2
`define DLI_C_SHAPE_START 8'he0
`define DLI_C_SHAPE_FINISH 8'he1
`define DLI_C_SHAPE_CLEAR 8'he2
`define DLI_C_NORMAL 8'hff

// ****************************************
// Reset values and host register map
// ****************************************
`define DLI_COORD_RESET 16'h0000
`define DLI_BOX_MIN_RESET 16'hffff
`define DLI_HOST_CTRL 32'h0000_0000
`define DLI_HOST_STAT 32'h0000_0004
`define DLI_HOST_DATA 32'h0000_0008
`define DLI_HOST_COUNT 32'h0000_000c
`define DLI_HOST_SRC 32'h0000_0010
`define DLI_HOST_DST_ADDR 32'h0000_0014
`define DLI_HOST_ADDR_DECODE_W 5

`endif

// file: hw/dli_pkg.sv
// Types shared by the display-list interpreter ends
package dli_pkg;
    typedef enum logic [1:0] {DLI_SRC_CPU, DLI_SRC_DMA, DLI_SRC_GMEM} dli_src_t;
    typedef enum logic [2:0] {
        DLI_RK_NONE, DLI_RK_POINT, DLI_RK_LINE, DLI_RK_TRI,
        DLI_RK_BLT, DLI_RK_TEX, DLI_RK_SHAPE, DLI_RK_FLUSH
    } dli_rkind_t;
    typedef struct packed {
        logic [7:0] code;
        dli_rkind_t kind;
        logic y_major;
        logic no_end;
        logic dash_clr;
        logic anti;
        logic quick;
        logic [1:0] copy_corner;
        logic from_gmem;
    } dli_draw_t;
endpackage

// file: hw/dli_if.sv
// Word link between list feeder and interpreter
`timescale 1ns/1ps
`default_nettype none
interface dli_if;
    logic [31:0] word;
    logic [1:0] src;
    logic valid;
    logic ready;
    modport feeder (output word, output src, output valid, input ready);
    modport interp (input word, input src, input valid, output ready);
endinterface
`default_nettype wire

// file: hw/dli_decode.sv
// Header type and draw sub-code decoder
`timescale 1ns/1ps
`default_nettype none
`include "dli_params.svh"
module dli_decode (
    input wire logic [7:0] type_code,
    input wire logic [7:0] draw_code,
    output logic known,
    output dli_pkg::dli_draw_t draw
);
    import dli_pkg::*;

    // ****************************************
    // Decoder
    // ****************************************
    always_comb begin
        draw = '0;
        draw.code = draw_code;
        case (type_code)
            `DLI_T_PIXEL, `DLI_T_POINT_PLOT_DEPTH, `DLI_T_LINE, `DLI_T_LINE2I, `DLI_T_LINE2IP,
            `DLI_T_TRAP, `DLI_T_VTX2I, `DLI_T_VTX2IP, `DLI_T_RECTP, `DLI_T_BMPP,
            `DLI_T_COPYP, `DLI_T_COPYALTP, `DLI_T_TEXP, `DLI_T_BLTTEXP,
            `DLI_T_VSET, `DLI_T_VSETP, `DLI_T_DRAW, `DLI_T_REGSET,
            `DLI_T_WAIT, `DLI_T_IRQ, `DLI_T_NOP: known = 1'b1;
            default: known = 1'b0;
        endcase
        case (draw_code[7:5])
            3'h0: draw.kind = DLI_RK_POINT;
            `DLI_G_LINE: begin
                draw.kind = DLI_RK_LINE;
                draw.y_major = draw_code[0];
                draw.no_end = draw_code[1];
                draw.dash_clr = draw_code[2];
                draw.anti = draw_code[3];
                draw.quick = draw_code[4];
            end
            `DLI_G_BLT: begin
                draw.kind = (draw_code[3]) ? DLI_RK_TEX : DLI_RK_BLT;
                draw.copy_corner = draw_code[1:0];
                draw.from_gmem = (type_code == `DLI_T_BLTTEXP);
            end
            `DLI_G_TRI: draw.kind = DLI_RK_TRI;
            `DLI_G_FLUSH: draw.kind = DLI_RK_FLUSH;
            `DLI_G_SHAPE: draw.kind = DLI_RK_SHAPE;
            default: draw.kind = DLI_RK_NONE;
        endcase
    end
endmodule
`default_nettype wire

// file: hw/dli_interp.sv
// Display-list interpreter, device end
// Operation
// - Execute commands strictly in list order
// - Accept words from CPU, DMA, graphics memory
// - Type 31:24, code 23:16, count words
// - Vertex 10 triangle only; 11 forbidden (vertex-set accepts 10 for any command; only quick lines flag it)
// - Decode type codes per code table
// - Interrupt command pulses host request, continues
// - Wait command holds until vertical sync
// - Register-set writes consecutive registers from address
// - Vertex-set loads X, Y into vertex
// - Packed vertex: Y high, X low
// - Shape start begins bounding rectangle
// - Shape finish fills, clears shape flags
// - Pixel drain flushes pixel pipeline
// - Depth drain flushes depth values
// - Draw command uses preloaded registers
// - Line sub-code bits decoded individually
// - Fast line direction from start vertex
// - Decode fill, copy, texture, triangle, shape
// - Copy starts at chosen corner
// - Texture load may come from graphics memory
// - Point plot, optional depth
`timescale 1ns/1ps
`default_nettype none
`include "dli_params.svh"
module dli_interp (
    input wire logic CLK,
    input wire logic RESET,
    dli_if.interp LIST,
    input wire logic VSYNC,
    input wire logic ENGINE_READY,
    output logic HOST_IRQ,
    output logic REG_WE,
    output logic [15:0] REG_ADDR,
    output logic [31:0] REG_DATA,
    output logic DRAW_GO,
    output dli_pkg::dli_draw_t DRAW_CMD,
    output logic [7:0] DRAW_TYPE,
    output logic [31:0] DRAW_PARAM,
    output logic DRAW_PARAM_VALID,
    output logic [1:0] VERTEX_SEL,
    output logic [15:0] VERTEX_X,
    output logic [15:0] VERTEX_Y,
    output logic VERTEX_WE,
    output logic [63:0] SHAPE_BOX,
    output logic SHAPE_FLAG_CLR,
    output logic PIXEL_DRAIN,
    output logic DEPTH_DRAIN,
    output logic BAD_VERTEX,
    output logic BUSY
);
    import dli_pkg::*;

    typedef enum logic [2:0] {
        DLI_S_HEAD, DLI_S_PARAM, DLI_S_WAIT, DLI_S_ISSUE, DLI_S_VTX_X, DLI_S_VTX_Y
    } dli_state_t;

    typedef struct packed {
        dli_state_t st;
        logic [7:0] type_code;
        logic [7:0] left;
        logic [15:0] addr;
        logic [1:0] vtx;
        logic shape_on;
        logic vs_sync1;
        logic vs_sync2;
        logic vs_prev;
        logic irq;
        logic reg_we;
        logic [31:0] reg_data;
        logic draw_go;
        dli_draw_t draw;
        logic [31:0] param;
        logic param_valid;
        logic vtx_we;
        logic [15:0] vx;
        logic [15:0] vy;
        logic [15:0] xmin;
        logic [15:0] ymin;
        logic [15:0] xmax;
        logic [15:0] ymax;
        logic flag_clr;
        logic pix_drain;
        logic z_drain;
        logic bad_vtx;
    } dli_core_t;

    dli_core_t s_reg;
    dli_core_t s_next;
    logic known;
    dli_draw_t dec;
    logic take;
    logic is_tri;

    // ****************************************
    // Header decode
    // ****************************************
    dli_decode u_dec (
        .type_code(LIST.word[`DLI_TYPE_HI:`DLI_TYPE_LO]),
        .draw_code(LIST.word[`DLI_CMD_HI:`DLI_CMD_LO]),
        .known(known),
        .draw(dec)
    );

    // Vertex check allows code 10 only when a triangle may use it
    function automatic logic vtx_bad(input logic [1:0] v, input logic tri_ok);
        vtx_bad = (v == 2'b11) || (v == 2'b10 && !tri_ok);
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************
    assign is_tri = (dec.kind == DLI_RK_TRI) || (LIST.word[`DLI_TYPE_HI:`DLI_TYPE_LO] == `DLI_T_VSET)
        || (LIST.word[`DLI_TYPE_HI:`DLI_TYPE_LO] == `DLI_T_VSETP);
    // Source id is not needed: all three feeds share one ordered stream
    assign take = LIST.valid && LIST.ready;
    assign LIST.ready = (s_reg.st == DLI_S_HEAD) || (s_reg.st == DLI_S_PARAM)
        || (s_reg.st == DLI_S_VTX_X) || (s_reg.st == DLI_S_VTX_Y);

    always_comb begin
        s_next = s_reg;
        s_next.vs_sync1 = VSYNC;
        s_next.vs_sync2 = s_reg.vs_sync1;
        s_next.vs_prev = s_reg.vs_sync2;
        s_next.irq = 1'b0;
        s_next.reg_we = 1'b0;
        s_next.draw_go = 1'b0;
        s_next.param_valid = 1'b0;
        s_next.vtx_we = 1'b0;
        s_next.flag_clr = 1'b0;
        s_next.pix_drain = 1'b0;
        s_next.z_drain = 1'b0;
        s_next.bad_vtx = 1'b0;
        case (s_reg.st)
            DLI_S_HEAD: begin
                if (take) begin
                    s_next.type_code = LIST.word[`DLI_TYPE_HI:`DLI_TYPE_LO];
                    s_next.left = LIST.word[`DLI_CNT_HI:`DLI_CNT_LO];
                    s_next.addr = LIST.word[`DLI_ADDR_HI:`DLI_ADDR_LO] - 16'h0001;
                    s_next.vtx = LIST.word[`DLI_VTX_HI:`DLI_VTX_LO];
                    s_next.draw = dec;
                    if (!known) begin
                        s_next.st = DLI_S_HEAD;
                    end else begin
                        case (LIST.word[`DLI_TYPE_HI:`DLI_TYPE_LO])
                            `DLI_T_IRQ: s_next.irq = 1'b1;
                            `DLI_T_WAIT: begin
                                if (LIST.word[`DLI_FLAG_VBL]) s_next.st = DLI_S_WAIT;
                            end
                            `DLI_T_REGSET: begin
                                if (LIST.word[`DLI_CNT_HI:`DLI_CNT_LO] != 8'h00) begin
                                    s_next.st = DLI_S_PARAM;
                                end
                            end
                            `DLI_T_VSET, `DLI_T_VSETP: begin
                                if (dec.code == `DLI_C_SHAPE_START) begin
                                    s_next.shape_on = 1'b1;
                                    s_next.xmin = `DLI_BOX_MIN_RESET;
                                    s_next.ymin = `DLI_BOX_MIN_RESET;
                                    s_next.xmax = `DLI_COORD_RESET;
                                    s_next.ymax = `DLI_COORD_RESET;
                                end
                                if (vtx_bad(LIST.word[`DLI_VTX_HI:`DLI_VTX_LO], is_tri)) begin
                                    s_next.bad_vtx = 1'b1;
                                end
                                s_next.st = DLI_S_VTX_X;
                            end
                            `DLI_T_DRAW: s_next.st = DLI_S_ISSUE;
                            `DLI_T_NOP: s_next.st = DLI_S_HEAD;
                            default: begin
                                // Other draw types, packed or not: header only, issued as one draw; no parameter words are taken
                                s_next.st = DLI_S_ISSUE;
                                if (dec.quick && vtx_bad(LIST.word[`DLI_VTX_HI:`DLI_VTX_LO], 1'b0))
                                begin
                                    s_next.bad_vtx = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
            DLI_S_PARAM: begin
                if (take) begin
                    s_next.reg_we = 1'b1;
                    s_next.reg_data = LIST.word;
                    s_next.addr = s_reg.addr + 16'h0001;
                    s_next.left = s_reg.left - 8'h01;
                    if (s_reg.left == 8'h01) s_next.st = DLI_S_HEAD;
                end
            end
            DLI_S_VTX_X: begin
                if (take) begin
                    if (s_reg.type_code == `DLI_T_VSETP) begin
                        s_next.vx = LIST.word[15:0];
                        s_next.vy = LIST.word[31:16];
                        s_next.vtx_we = 1'b1;
                        s_next.st = DLI_S_HEAD;
                    end else begin
                        s_next.vx = LIST.word[15:0];
                        s_next.st = DLI_S_VTX_Y;
                    end
                end
            end
            DLI_S_VTX_Y: begin
                if (take) begin
                    s_next.vy = LIST.word[15:0];
                    s_next.vtx_we = 1'b1;
                    s_next.st = DLI_S_HEAD;
                end
            end
            DLI_S_WAIT: begin
                if (s_reg.vs_sync2 && !s_reg.vs_prev) s_next.st = DLI_S_HEAD;
            end
            DLI_S_ISSUE: begin
                // Engine back-pressure holds the list, keeping order intact
                if (ENGINE_READY) begin
                    s_next.draw_go = 1'b1;
                    s_next.st = DLI_S_HEAD;
                    if (s_reg.type_code == `DLI_T_DRAW) begin
                        s_next.pix_drain = (s_reg.draw.code == `DLI_C_PIX_DRAIN);
                        s_next.z_drain = (s_reg.draw.code == `DLI_C_Z_DRAIN);
                        if (s_reg.draw.code == `DLI_C_SHAPE_FINISH) begin
                            s_next.flag_clr = 1'b1;
                            s_next.shape_on = 1'b0;
                        end
                    end
                end
            end
            default: s_next.st = DLI_S_HEAD;
        endcase
        // Bounding box grows on each vertex loaded while a shape is open
        if (s_reg.vtx_we && s_reg.shape_on) begin
            if (s_reg.vx < s_reg.xmin) s_next.xmin = s_reg.vx;
            if (s_reg.vy < s_reg.ymin) s_next.ymin = s_reg.vy;
            if (s_reg.vx > s_reg.xmax) s_next.xmax = s_reg.vx;
            if (s_reg.vy > s_reg.ymax) s_next.ymax = s_reg.vy;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s_reg <= '0;
            s_reg.xmin <= `DLI_BOX_MIN_RESET;
            s_reg.ymin <= `DLI_BOX_MIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign HOST_IRQ = s_reg.irq;
    assign REG_WE = s_reg.reg_we;
    assign REG_ADDR = s_reg.addr;
    assign REG_DATA = s_reg.reg_data;
    assign DRAW_GO = s_reg.draw_go;
    assign DRAW_CMD = s_reg.draw;
    assign DRAW_TYPE = s_reg.type_code;
    assign DRAW_PARAM = s_reg.param;
    assign DRAW_PARAM_VALID = s_reg.param_valid;
    assign VERTEX_SEL = s_reg.vtx;
    assign VERTEX_X = s_reg.vx;
    assign VERTEX_Y = s_reg.vy;
    assign VERTEX_WE = s_reg.vtx_we;
    assign SHAPE_BOX = {s_reg.ymax, s_reg.xmax, s_reg.ymin, s_reg.xmin};
    assign SHAPE_FLAG_CLR = s_reg.flag_clr;
    assign PIXEL_DRAIN = s_reg.pix_drain;
    assign DEPTH_DRAIN = s_reg.z_drain;
    assign BAD_VERTEX = s_reg.bad_vtx;
    assign BUSY = (s_reg.st != DLI_S_HEAD);
endmodule
`default_nettype wire

// file: hw/dli_feeder.sv
// List feeder end: APB data register pushes CPU words; burst port pushes words from DMA or graphics memory
`timescale 1ns/1ps
`default_nettype none
`include "dli_params.svh"
module dli_feeder (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [31:0] MEM_WORD,
    input wire logic MEM_VALID,
    output logic MEM_READY,
    dli_if.feeder LIST
);
    import dli_pkg::*;

    typedef struct packed {
        logic [31:0] word;
        logic [1:0] src;
        logic valid;
        logic [15:0] count;
        logic [1:0] bsrc;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [31:0] sent;
    } dli_feed_t;

    dli_feed_t f_reg;
    dli_feed_t f_next;
    logic acc;

    // ****************************************
    // Feed and APB slave
    // ****************************************
    assign acc = PSEL && PENABLE && !f_reg.pready;
    assign MEM_READY = (f_reg.count != 16'h0000) && f_reg.bsrc != DLI_SRC_CPU
        && (!f_reg.valid || LIST.ready);

    always_comb begin
        f_next = f_reg;
        f_next.pready = 1'b0;
        f_next.pslverr = 1'b0;
        if (f_reg.valid && LIST.ready) begin
            f_next.valid = 1'b0;
            f_next.sent = f_reg.sent + 32'h1;
        end
        // Burst words from DMA or graphics memory, one per cycle
        if (MEM_READY && MEM_VALID) begin
            f_next.word = MEM_WORD;
            f_next.src = f_reg.bsrc;
            f_next.valid = 1'b1;
            f_next.count = f_reg.count - 16'h0001;
        end
        if (acc) begin
            // CPU data writes wait while the slot is full: back-pressure via PREADY
            f_next.pready = 1'b1;
            f_next.prdata = 32'h0;
            case (PADDR)
                `DLI_HOST_DATA: begin
                    if (PWRITE) begin
                        if (f_next.valid) f_next.pready = 1'b0;
                        else begin
                            f_next.word = PWDATA;
                            f_next.src = DLI_SRC_CPU;
                            f_next.valid = 1'b1;
                        end
                    end
                end
                `DLI_HOST_COUNT: begin
                    if (PWRITE) f_next.count = PWDATA[15:0];
                    else f_next.prdata = {16'h0, f_reg.count};
                end
                `DLI_HOST_SRC: begin
                    if (PWRITE) f_next.bsrc = dli_src_t'(PWDATA[1:0]);
                    else f_next.prdata = {30'h0, f_reg.bsrc};
                end
                `DLI_HOST_STAT: begin
                    if (!PWRITE) f_next.prdata = {31'h0, f_reg.valid};
                end
                `DLI_HOST_CTRL: begin
                    if (!PWRITE) f_next.prdata = f_reg.sent;
                end
                default: f_next.pslverr = 1'b1;
            endcase
            f_next.pslverr = f_next.pslverr && f_next.pready;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) f_reg <= '0;
        else f_reg <= f_next;
    end

    assign LIST.word = f_reg.word;
    assign LIST.src = f_reg.src;
    assign LIST.valid = f_reg.valid;
    assign PRDATA = f_reg.prdata;
    assign PREADY = f_reg.pready;
    assign PSLVERR = f_reg.pslverr;
endmodule
`default_nettype wire

// file: verification/dli_asserts.sv
// Assertions on the list word link and interpreter pulses
`timescale 1ns/1ps
`default_nettype none
module dli_asserts (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [31:0] word,
    input wire logic [1:0] src,
    input wire logic valid,
    input wire logic ready,
    input wire logic BUSY,
    input wire logic HOST_IRQ,
    input wire logic DRAW_GO,
    input wire logic PIXEL_DRAIN,
    input wire logic DEPTH_DRAIN
);
    // ****************
    // Header taken
    // ****************
    // Only an idle interpreter takes a header word
    wire logic hdr = valid && ready && !BUSY;
    wire logic [7:0] ty = word[31:24];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    hold_word_a: assert property (
        valid && !ready |=> valid && $stable(word) && $stable(src))
        else $error("list word changed before taken");
    src_legal_a: assert property (valid |-> src != 2'h3)
        else $error("list source code out of range");
    irq_cause_a: assert property (hdr && ty == 8'hfd |=> HOST_IRQ)
        else $error("interrupt header raised no request");
    irq_only_a: assert property (
        HOST_IRQ |-> $past(hdr) && $past(ty) == 8'hfd && !$past(HOST_IRQ))
        else $error("interrupt request without its header");
    wait_flag_a: assert property (hdr && ty == 8'hfc |=> BUSY == $past(word[0]))
        else $error("wait flag handled wrongly");
    skip_type_a: assert property (
        hdr && (ty == 8'hff || ty == 8'h20) |=> !BUSY && !DRAW_GO && !HOST_IRQ)
        else $error("skipped header had an effect");
    regset_busy_a: assert property (hdr && ty == 8'hf1 && word[23:16] != 8'h00 |=> BUSY)
        else $error("register-set did not wait for its words");
    draw_go_a: assert property (hdr && ty == 8'hf0 |-> ##[1:40] DRAW_GO)
        else $error("draw header issued nothing");
    drain_go_a: assert property (PIXEL_DRAIN || DEPTH_DRAIN |-> DRAW_GO)
        else $error("drain pulse outside a draw issue");
endmodule
`default_nettype wire

// file: verification/display_list_interpreter_test.sv
// Bench driving both interpreter ends over APB and the burst port
`timescale 1ns/1ps
`default_nettype none
`include "dli_params.svh"
module display_list_interpreter_test;
    import dli_pkg::*;
    logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic MEM_VALID = 1'b0, VSYNC = 1'b0, ENGINE_READY = 1'b1, PREADY, PSLVERR, MEM_READY;
    logic HOST_IRQ, REG_WE, DRAW_GO, DRAW_PARAM_VALID, VERTEX_WE, SHAPE_FLAG_CLR;
    logic PIXEL_DRAIN, DEPTH_DRAIN, BAD_VERTEX, BUSY, er;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, MEM_WORD = 32'h0, PRDATA, REG_DATA;
    logic [31:0] DRAW_PARAM, rd, seed = 32'hbf9d45f5;
    logic [15:0] REG_ADDR, VERTEX_X, VERTEX_Y;
    logic [7:0] DRAW_TYPE;
    logic [1:0] VERTEX_SEL, sq;
    logic [63:0] SHAPE_BOX;
    logic [47:0] wq[$];
    dli_draw_t DRAW_CMD, dq;
    int failures = 0, cmp_count = 0, irqs = 0, gos = 0, bads = 0, drains = 0, clrs = 0;
    dli_if LIST ();
    dli_feeder i_dli_feeder (.*);
    dli_interp i_dli_interp (.*);
    dli_asserts u_chk (.CLK(CLK), .RESET(RESET), .word(LIST.word), .src(LIST.src),
        .valid(LIST.valid), .ready(LIST.ready), .BUSY(BUSY), .HOST_IRQ(HOST_IRQ),
        .DRAW_GO(DRAW_GO), .PIXEL_DRAIN(PIXEL_DRAIN), .DEPTH_DRAIN(DEPTH_DRAIN));
    initial forever #5 CLK = ~CLK;
    // ****************
    // Monitor and tasks
    // ****************
    always @(posedge CLK) begin
        if (REG_WE === 1'b1) wq.push_back({REG_ADDR, REG_DATA});
        if (HOST_IRQ === 1'b1) irqs++;
        if (BAD_VERTEX === 1'b1) bads++;
        if (SHAPE_FLAG_CLR === 1'b1) clrs++;
        if (PIXEL_DRAIN === 1'b1 || DEPTH_DRAIN === 1'b1) drains++;
        if (LIST.valid === 1'b1 && LIST.ready === 1'b1) sq = LIST.src;
        if (DRAW_GO === 1'b1) begin
            gos++;
            dq = DRAW_CMD;
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic hang();
        failures++;
        stop_test();
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 200);
        if (n >= 200) hang();
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        PWDATA <= ~d;
    endtask
    task automatic push(input logic [31:0] w);
        apb(1'b1, `DLI_HOST_DATA, w);
    endtask
    task automatic mem(input logic [31:0] w);
        int n;
        @(posedge CLK);
        MEM_WORD <= w;
        MEM_VALID <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (MEM_READY !== 1'b1 && n < 200);
        if (n >= 200) hang();
        MEM_VALID <= 1'b0;
        MEM_WORD <= ~w;
    endtask
    // Settling edges let registered pulses reach the monitor
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while ((BUSY !== 1'b0 || LIST.valid !== 1'b0) && n < 300);
        if (n >= 300) hang();
        repeat (3) @(posedge CLK);
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        logic [7:0] n;
        logic [15:0] a;
        logic [31:0] d[4];
        logic [7:0] c[9];
        c = '{8'h3f, 8'h20, 8'h30, 8'h31, 8'h44, 8'h47, 8'hc1, 8'hc2, 8'he1};
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            seed = nx(seed);
            n = 8'(seed[1:0]) + 8'h1;
            a = seed[31:16];
            push({8'hf1, n, a});
            for (int i = 0; i < n; i++) begin
                seed = nx(seed);
                d[i] = seed;
                push(seed);
            end
            idle();
            chk("reg writes", 64'(n), 64'(wq.size()));
            for (int i = 0; i < n; i++) chk("reg word", {a + 16'(i), d[i]}, wq[i]);
            wq.delete();
        end
        $display("register-set test done");
        push(32'hfd000000);
        push(32'hff000000);
        push(32'h20000000);
        push(32'hfc000000);
        push(32'hfd000000);
        idle();
        chk("irq count", 64'h2, 64'(irqs));
        push(32'hfc000001);
        push(32'hfd000000);
        repeat (20) @(posedge CLK);
        chk("irq held", 64'h2, 64'(irqs));
        VSYNC <= 1'b1;
        idle();
        VSYNC <= 1'b0;
        chk("irq after sync", 64'h3, 64'(irqs));
        $display("interrupt and wait test done");
        seed = nx(seed);
        push({8'h70, 8'hff, 16'h0001});
        push({16'h0, seed[15:0]});
        push({16'h0, seed[31:16]});
        idle();
        chk("vertex", {2'b01, seed}, {VERTEX_SEL, VERTEX_Y, VERTEX_X});
        push({8'h71, 8'hff, 16'h0000});
        push(~seed);
        idle();
        chk("packed vertex", {2'b00, ~seed}, {VERTEX_SEL, VERTEX_Y, VERTEX_X});
        push({8'h70, 8'he0, 16'h0003});
        push(32'h0);
        push(32'h0);
        idle();
        chk("bad vertex", 64'h1, 64'(bads));
        push({8'h71, 8'hff, 16'h0000});
        push(seed);
        idle();
        chk("shape box", {seed, 32'h0}, SHAPE_BOX);
        $display("vertex test done");
        foreach (c[i]) begin
            push({8'hf0, c[i], 16'h0});
            idle();
            chk("draw code", c[i], dq.code);
            chk("draw count", 64'(i + 1), 64'(gos));
            if (c[i][7:5] == 3'h1)
                chk("line bits", {c[i][0], c[i][1], c[i][2], c[i][3], c[i][4]},
                    {dq.y_major, dq.no_end, dq.dash_clr, dq.anti, dq.quick});
            if (c[i][7:2] == 6'h11) chk("corner", c[i][1:0], dq.copy_corner);
        end
        chk("drains", 64'h2, 64'(drains));
        chk("flag clear", 64'h1, 64'(clrs));
        $display("draw test done");
        for (int s = 1; s < 3; s++) begin
            seed = nx(seed);
            apb(1'b1, `DLI_HOST_COUNT, 32'h3);
            apb(1'b1, `DLI_HOST_SRC, 32'(s));
            d = '{{8'hf1, 8'h02, seed[15:0]}, ~seed, seed, 32'h0};
            for (int i = 0; i < 3; i++) mem(d[i]);
            idle();
            chk("burst source", 64'(s), 64'(sq));
            chk("burst write", {seed[15:0] + 16'h1, seed}, wq[1]);
            wq.delete();
        end
        apb(1'b0, 32'h40, 32'h0);
        chk("unmapped error", 64'h1, 64'(er));
        apb(1'b0, `DLI_HOST_STAT, 32'h0);
        chk("slot empty", 64'h0, 64'(rd[0]));
        $display("burst and bus test done");
        stop_test();
    end
endmodule
`default_nettype wire
